/* wdt_pkg.sv */
package wdt_pkg;
  // clock rates, used to check that the oscillator can be sampled
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned OSC_CLK_HZ = 128_000;
  localparam int unsigned OSC_CORE_CYCLES = CORE_CLK_HZ / OSC_CLK_HZ;
  // register location on the core i/o space
  localparam logic [5:0] CTRL_ADDR = 6'h31;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // field positions in the control register
  localparam int unsigned BIT_IRQ_FLAG = 7;
  localparam int unsigned BIT_IRQ_EN = 6;
  localparam int unsigned BIT_PERIOD_TOP = 5;
  localparam int unsigned BIT_RST_EN = 3;
  localparam int unsigned BIT_PERIOD_LO = 0;
  // protected write window length in instruction cycles
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
  // period encoding
  localparam int unsigned CNT_W = 20;
  localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
  localparam logic [CNT_W-1:0] BASE_CYCLES_M1 = 20'h007FF;

  // last count value before expiry; reserved codes act as the longest
  function automatic logic [CNT_W-1:0] period_last(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : code;
    period_last = (BASE_CYCLES_M1 << c) | ((20'h00001 << c) - 20'h00001);
  endfunction : period_last
endpackage : wdt_pkg

/* wdt_prescale_counter.sv */
`timescale 1ns/100ps
module wdt_prescale_counter
  import wdt_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic [3:0] period_in,
  output logic expire_out,
  output logic [WIDTH-1:0] count_out
);
  // the period table is built for one width only
  if (WIDTH != CNT_W) begin : g_bad_width
    $error("counter width must match period table");
  end

  // last value for the selected period
  logic [WIDTH-1:0] last;
  assign last = period_last(period_in);

  // oscillator cycle counter, cleared on restart or disable
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_out <= '0;
    end else if (clear_in) begin
      count_out <= '0;
    end else if (tick_in) begin
      // wraps at expiry so the next period starts afresh
      count_out <= (count_out >= last) ? '0 : count_out + 1'b1;
    end
  end

  // expiry is a one-cycle pulse in the cycle after the tick that ends the period
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      expire_out <= 1'b0;
    end else begin
      expire_out <= tick_in && !clear_in && (count_out >= last);
    end
  end

  property p_expire_at_last;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (tick_in && !clear_in && count_out == last) |=> expire_out;
  endproperty
  a_expire_at_last: assert property (p_expire_at_last)
    else $error("period end did not expire");
endmodule : wdt_prescale_counter

/* watchdog_timer_unit.sv */
// Contract
// - count a dedicated 128 kHz oscillator
// - restart instruction clears the counter
// - disable or device reset clears counter
// - reset mode time-out requests system reset
// - fuse picks level one or two
// - level one enables freely by writing one
// - level two always on, enable reads one
// - level two period change needs unlock
// - interrupt mode time-out sets the flag
// - vector or writing one clears flag
// - request needs flag, enable and global enable
// - enable bits select mode; fuse forces reset
// - combined mode vector drops to reset-only
// - unserviced second time-out resets in combined
// - watchdog reset flag forces reset enable
// - codes double 2048 cycles; upper reserved
// - period top bit 5, low bits 2:0
// - keeps running in every sleep mode
// - reset request lasts one core cycle
// - watchdog reset flag set, cleared properly
`timescale 1ns/100ps
module watchdog_timer_unit
  import wdt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic por_resetn_in,
  input wire logic osc_clk_in,
  input wire logic watchdog_always_on_fuse_in,
  input wire logic restart_in,
  input wire logic unlock_sig_in,
  input wire logic [5:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic irq_ack_in,
  input wire logic global_irq_en_in,
  input wire logic reset_flag_clear_in,
  output logic [7:0] io_rdata_out,
  output logic irq_out,
  output logic sys_reset_req_out,
  output logic watchdog_caused_reset_flag_out
);
  // the oscillator is sampled, so the core must be well above it
  if (OSC_CORE_CYCLES < 4) begin : g_slow_core
    $error("core clock too slow for oscillator");
  end

  // control register fields
  logic timeout_irq_flag; // sticky time-out flag
  logic timeout_irq_enable; // interrupt enable
  logic timeout_reset_enable; // stored reset enable
  logic [3:0] period_select; // time-out code

  // derived state
  logic fuse; // level two when set
  logic rst_en_eff; // reset enable as seen by logic and reads
  logic wdt_enabled; // counter allowed to run
  logic ctrl_wr; // write to the control register
  logic ctrl_rd; // read of the control register
  logic win_open; // unlock window open
  logic [2:0] win_cnt; // remaining instruction cycles of the window
  logic prot_wr; // control write inside the window
  logic mode_irq_only; // interrupt mode
  logic mode_combined; // interrupt then reset mode
  logic mode_reset; // reset on time-out
  logic expire; // one-cycle time-out pulse
  logic [CNT_W-1:0] count; // counter value, watched only
  logic osc_sync1; // first synchroniser stage
  logic osc_sync2; // second synchroniser stage
  logic osc_prev; // previous synchronised level
  logic osc_tick; // one pulse per oscillator cycle
  logic next_flag; // next value of the time-out flag

  assign fuse = watchdog_always_on_fuse_in;
  // the reset flag holds reset enable up so a failing loop keeps resetting
  assign rst_en_eff = timeout_reset_enable | fuse
                    | watchdog_caused_reset_flag_out;
  assign ctrl_wr = io_wr_in && (io_addr_in == CTRL_ADDR);
  assign ctrl_rd = io_rd_in && (io_addr_in == CTRL_ADDR);
  assign win_open = (win_cnt != 3'h0);
  assign prot_wr = ctrl_wr && win_open;

  // mode decode; with the fuse programmed only reset mode exists
  assign mode_irq_only = !fuse && !rst_en_eff && timeout_irq_enable;
  assign mode_combined = !fuse && rst_en_eff && timeout_irq_enable;
  assign mode_reset = fuse || (rst_en_eff && !timeout_irq_enable);
  assign wdt_enabled = fuse || rst_en_eff || timeout_irq_enable;

  // oscillator level into the core domain: two flops, then edge detect
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_sync1 <= osc_clk_in;
      osc_sync2 <= osc_sync1;
      osc_prev <= osc_sync2;
    end
  end
  // sleep does not gate this path; the counter keeps ticking
  assign osc_tick = osc_sync2 && !osc_prev;

  // prescaled counter of oscillator cycles
  wdt_prescale_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .tick_in(osc_tick),
    .clear_in(restart_in || !wdt_enabled),
    .period_in(period_select),
    .expire_out(expire),
    .count_out(count)
  );

  // unlock window: four instruction cycles, closed by one protected write
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      win_cnt <= 3'h0;
    end else if (unlock_sig_in) begin
      win_cnt <= UNLOCK_WINDOW;
    end else if (prot_wr) begin
      win_cnt <= 3'h0;
    end else if (win_open) begin
      win_cnt <= win_cnt - 3'h1;
    end
  end

  // reset enable bit
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timeout_reset_enable <= 1'b0;
    end else if (ctrl_wr && !fuse) begin
      if (io_wdata_in[BIT_RST_EN]) begin
        timeout_reset_enable <= 1'b1;
      end else if (win_open && !watchdog_caused_reset_flag_out) begin
        // clearing is protected and blocked while the reset flag stands
        timeout_reset_enable <= 1'b0;
      end
    end
    // at level two the written enable value is ignored
  end

  // period bits: free at level one, protected at level two
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      period_select <= 4'h0;
    end else if (ctrl_wr && (!fuse || win_open)) begin
      period_select <= {io_wdata_in[BIT_PERIOD_TOP],
                        io_wdata_in[BIT_PERIOD_LO+2:BIT_PERIOD_LO]};
    end
  end

  // interrupt enable: software write, hardware clear on combined vector
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timeout_irq_enable <= 1'b0;
    end else if (irq_ack_in && mode_combined) begin
      // vector drops to reset-only; software must re-arm later
      timeout_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      timeout_irq_enable <= io_wdata_in[BIT_IRQ_EN];
    end
  end

  // time-out flag: hardware set wins over vector or write-one clear
  always_comb begin
    next_flag = timeout_irq_flag;
    if (irq_ack_in) begin
      next_flag = 1'b0;
    end
    if (ctrl_wr && io_wdata_in[BIT_IRQ_FLAG]) begin
      next_flag = 1'b0;
    end
    if (expire && (mode_irq_only || mode_combined)) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timeout_irq_flag <= 1'b0;
    end else begin
      timeout_irq_flag <= next_flag;
    end
  end

  // system reset request; combined mode resets only on an unserviced flag
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_reset_req_out <= 1'b0;
    end else begin
      // a single core cycle, the cycle after the expiry pulse
      sys_reset_req_out <= expire && (mode_reset
                           || (mode_combined && timeout_irq_flag));
    end
  end

  // watchdog reset flag survives system reset; power-on or reset_flag_clear_in clears it
  always_ff @(posedge core_clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      watchdog_caused_reset_flag_out <= 1'b0;
    end else if (sys_reset_req_out) begin
      watchdog_caused_reset_flag_out <= 1'b1;
    end else if (reset_flag_clear_in) begin
      watchdog_caused_reset_flag_out <= 1'b0;
    end
  end

  // interrupt request to the core
  assign irq_out = timeout_irq_flag && timeout_irq_enable
                   && global_irq_en_in;

  // registered read data; other addresses read as zero
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      io_rdata_out <= CTRL_RESET;
    end else if (ctrl_rd) begin
      io_rdata_out <= {timeout_irq_flag, timeout_irq_enable,
                       period_select[3], 1'b0, rst_en_eff,
                       period_select[2:0]};
    end else begin
      io_rdata_out <= 8'h00;
    end
  end

  // checks
  property p_reset_one_cycle;
    @(posedge core_clk_in) disable iff (!resetn_in)
    sys_reset_req_out |=> !sys_reset_req_out;
  endproperty
  a_reset_one_cycle: assert property (p_reset_one_cycle)
    else $error("reset request longer than one cycle");

  property p_watchdog_caused_reset_flag_after_reset;
    @(posedge core_clk_in) disable iff (!por_resetn_in)
    sys_reset_req_out |=> watchdog_caused_reset_flag_out;
  endproperty
  a_watchdog_caused_reset_flag_after_reset: assert property (p_watchdog_caused_reset_flag_after_reset)
    else $error("reset flag not set after watchdog reset");

  property p_reset_in_reset_mode;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (expire && mode_reset) |=> sys_reset_req_out;
  endproperty
  a_reset_in_reset_mode: assert property (p_reset_in_reset_mode)
    else $error("no reset on time-out in reset mode");

  property p_combined_second;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (expire && mode_combined && timeout_irq_flag) |=> sys_reset_req_out;
  endproperty
  a_combined_second: assert property (p_combined_second)
    else $error("unserviced time-out did not reset");

  property p_flag_on_timeout;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (expire && mode_irq_only) |=> timeout_irq_flag && !sys_reset_req_out;
  endproperty
  a_flag_on_timeout: assert property (p_flag_on_timeout)
    else $error("interrupt mode time-out lost");

  property p_ack_clears;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (irq_ack_in && !expire) |=> !timeout_irq_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("vector did not clear flag");

  property p_level2_reads_one;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ctrl_rd && fuse) |=> io_rdata_out[BIT_RST_EN];
  endproperty
  a_level2_reads_one: assert property (p_level2_reads_one)
    else $error("reset enable read zero at level two");

  property p_period_locked;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (fuse && !win_open) |=> $stable(period_select);
  endproperty
  a_period_locked: assert property (p_period_locked)
    else $error("period changed without unlock");

  property p_restart_clears;
    @(posedge core_clk_in) disable iff (!resetn_in)
    restart_in |=> (count == '0);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear counter");

  property p_disabled_idle;
    @(posedge core_clk_in) disable iff (!resetn_in)
    !wdt_enabled |=> (count == '0) && !sys_reset_req_out;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled watchdog still counting");

  // level two never sets the flag, so no request can appear there
  property p_irq_gate;
    @(posedge core_clk_in) disable iff (!resetn_in)
    irq_out |-> timeout_irq_flag && timeout_irq_enable
                && global_irq_en_in && !fuse;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request without all enables");

  property p_window_closes;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (prot_wr && !unlock_sig_in) |=> !win_open;
  endproperty
  a_window_closes: assert property (p_window_closes)
    else $error("unlock window survived a protected write");

  property p_level1_enable_free;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ctrl_wr && !fuse && io_wdata_in[BIT_RST_EN]) |=> rst_en_eff;
  endproperty
  a_level1_enable_free: assert property (p_level1_enable_free)
    else $error("enable write ignored at level one");

  property p_vector_drops_combined;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (irq_ack_in && mode_combined && !expire)
      |=> !timeout_irq_enable && !timeout_irq_flag;
  endproperty
  a_vector_drops_combined: assert property (p_vector_drops_combined)
    else $error("combined vector did not drop to reset only");

  property p_flag_w1_clears;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (ctrl_wr && io_wdata_in[BIT_IRQ_FLAG] && !expire) |=> !timeout_irq_flag;
  endproperty
  a_flag_w1_clears: assert property (p_flag_w1_clears)
    else $error("writing one did not clear the flag");
endmodule : watchdog_timer_unit

/* test_watchdog_timer_unit.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end
module test_watchdog_timer_unit;
  import wdt_pkg::*;
  // oscillator runs at a quarter of the core clock to keep runs short
  localparam int OSC_DIV = 4;
  localparam int P_RESTART = 0;
  localparam int P_UNLOCK = 1;
  localparam int P_ACK = 2;
  localparam int P_FLAG_CLR = 3;
  logic core_clk_in, resetn_in, por_resetn_in, osc_clk_in;
  logic watchdog_always_on_fuse_in, restart_in, unlock_sig_in;
  logic [5:0] io_addr_in;
  logic io_wr_in, io_rd_in, irq_ack_in, global_irq_en_in;
  logic [7:0] io_wdata_in;
  logic reset_flag_clear_in;
  logic [7:0] io_rdata_out;
  logic irq_out, sys_reset_req_out, watchdog_caused_reset_flag_out;
  logic [1:0] osc_div; // oscillator divider
  int fails; // mismatch count
  int checked; // comparison count
  int waited; // cycles spent in the last wait

  watchdog_timer_unit dut_u (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .por_resetn_in(por_resetn_in), .osc_clk_in(osc_clk_in),
    .watchdog_always_on_fuse_in(watchdog_always_on_fuse_in),
    .restart_in(restart_in), .unlock_sig_in(unlock_sig_in),
    .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in), .irq_ack_in(irq_ack_in),
    .global_irq_en_in(global_irq_en_in),
    .reset_flag_clear_in(reset_flag_clear_in),
    .io_rdata_out(io_rdata_out), .irq_out(irq_out),
    .sys_reset_req_out(sys_reset_req_out),
    .watchdog_caused_reset_flag_out(watchdog_caused_reset_flag_out));

  // core clock, 100 ns period
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // oscillator made on the core edge; high two cycles so the syncer sees it
  always @(posedge core_clk_in) begin
    osc_div <= osc_div + 2'h1;
    osc_clk_in <= osc_div[1];
  end

  task give_verdict();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc

  // one-cycle strobe on the selected core event
  task pulse(input int sel);
    @(posedge core_clk_in);
    case (sel)
      P_RESTART: restart_in <= 1'b1;
      P_UNLOCK: unlock_sig_in <= 1'b1;
      P_ACK: irq_ack_in <= 1'b1;
      default: reset_flag_clear_in <= 1'b1;
    endcase
    @(posedge core_clk_in);
    restart_in <= 1'b0;
    unlock_sig_in <= 1'b0;
    irq_ack_in <= 1'b0;
    reset_flag_clear_in <= 1'b0;
  endtask : pulse

  task wr(input logic [7:0] d);
    @(posedge core_clk_in);
    io_addr_in <= CTRL_ADDR;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge core_clk_in);
    io_wr_in <= 1'b0;
  endtask : wr

  // read data is registered, so it is looked at one edge after the strobe
  task rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge core_clk_in);
    io_rd_in <= 1'b0;
    #1;
    `CHK(io_rdata_out, exp)
  endtask : rd

  // bounded wait for the interrupt line or the reset request
  task wait_ev(input bit rst_ev, input int lim);
    waited = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      waited++;
    end while ((rst_ev ? sys_reset_req_out : irq_out) !== 1'b1
               && waited < lim);
    if (waited >= lim) begin
      fails++;
      $display("MISMATCH t=%0t wait limit reached", $time);
      give_verdict();
    end
  endtask : wait_ev

  initial begin
    fails = 0;
    checked = 0;
    osc_div = 2'h0;
    osc_clk_in = 1'b0;
    resetn_in = 1'b0;
    por_resetn_in = 1'b0;
    watchdog_always_on_fuse_in = 1'b0;
    {restart_in, unlock_sig_in, io_wr_in, io_rd_in} = 4'h0;
    {irq_ack_in, reset_flag_clear_in} = 2'h0;
    global_irq_en_in = 1'b1;
    io_addr_in = CTRL_ADDR;
    io_wdata_in = 8'h00;
    cyc(20);
    resetn_in <= 1'b1;
    por_resetn_in <= 1'b1;
    // level one register access
    rd(CTRL_ADDR, CTRL_RESET);
    rd(6'h30, 8'h00);
    wr(8'h08);
    rd(CTRL_ADDR, 8'h08);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h08);
    wr(8'h39);
    rd(CTRL_ADDR, 8'h29);
    pulse(P_UNLOCK);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h00);
    // interrupt mode: restarts hold off the time-out
    wr(8'h40);
    pulse(P_RESTART);
    cyc(1400 * OSC_DIV);
    pulse(P_RESTART);
    cyc(1400 * OSC_DIV);
    rd(CTRL_ADDR, 8'h40);
    pulse(P_RESTART);
    wait_ev(1'b0, 2100 * OSC_DIV);
    // tick comes 3 edges after the rise, then expiry, then the flag
    `CHK(waited >= 2048*OSC_DIV-2 && waited <= 2048*OSC_DIV+1, 1'b1)
    rd(CTRL_ADDR, 8'hC0);
    @(posedge core_clk_in) global_irq_en_in <= 1'b0;
    @(posedge core_clk_in) #1;
    `CHK(irq_out, 1'b0)
    global_irq_en_in <= 1'b1;
    // writing one clears the flag; code one doubles the period
    wr(8'hC1);
    rd(CTRL_ADDR, 8'h41);
    pulse(P_RESTART);
    wait_ev(1'b0, 4200 * OSC_DIV);
    `CHK(waited >= 4096*OSC_DIV-2 && waited <= 4096*OSC_DIV+1, 1'b1)
    pulse(P_ACK);
    rd(CTRL_ADDR, 8'h41);
    // combined mode, serviced: vector drops to reset only
    wr(8'hC8);
    pulse(P_RESTART);
    wait_ev(1'b0, 2100 * OSC_DIV);
    `CHK(sys_reset_req_out, 1'b0)
    pulse(P_ACK);
    rd(CTRL_ADDR, 8'h08);
    wait_ev(1'b1, 2100 * OSC_DIV);
    @(posedge core_clk_in) #1;
    `CHK(sys_reset_req_out, 1'b0)
    `CHK(watchdog_caused_reset_flag_out, 1'b1)
    // reset flag pins the reset enable until it is cleared
    pulse(P_UNLOCK);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h08);
    pulse(P_FLAG_CLR);
    @(posedge core_clk_in) #1;
    `CHK(watchdog_caused_reset_flag_out, 1'b0)
    pulse(P_UNLOCK);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h00);
    // combined mode, unserviced: second time-out resets
    wr(8'h48);
    pulse(P_RESTART);
    wait_ev(1'b0, 2100 * OSC_DIV);
    wait_ev(1'b1, 2100 * OSC_DIV);
    // device reset keeps the flag; power-on clears it
    @(posedge core_clk_in) resetn_in <= 1'b0;
    cyc(2);
    resetn_in <= 1'b1;
    rd(CTRL_ADDR, 8'h08);
    `CHK(watchdog_caused_reset_flag_out, 1'b1)
    @(posedge core_clk_in) por_resetn_in <= 1'b0;
    @(posedge core_clk_in) por_resetn_in <= 1'b1;
    rd(CTRL_ADDR, 8'h00);
    // level two: fuse is static, so it only changes under reset
    @(posedge core_clk_in) resetn_in <= 1'b0;
    watchdog_always_on_fuse_in <= 1'b1;
    cyc(2);
    resetn_in <= 1'b1;
    rd(CTRL_ADDR, 8'h08);
    wr(8'h01);
    rd(CTRL_ADDR, 8'h08);
    pulse(P_UNLOCK);
    cyc(2);
    wr(8'h01);
    rd(CTRL_ADDR, 8'h09);
    pulse(P_UNLOCK);
    cyc(3);
    wr(8'h02);
    rd(CTRL_ADDR, 8'h09);
    pulse(P_UNLOCK);
    wr(8'h03);
    wr(8'h04);
    rd(CTRL_ADDR, 8'h0B);
    // level two resets on time-out even with interrupts enabled
    pulse(P_UNLOCK);
    wr(8'h40);
    rd(CTRL_ADDR, 8'h48);
    pulse(P_RESTART);
    wait_ev(1'b1, 2100 * OSC_DIV);
    rd(CTRL_ADDR, 8'h48);
    give_verdict();
  end
endmodule : test_watchdog_timer_unit
